// ==== rtl/ppsd_top.sv ====
`timescale 1ns/10ps
module ppsd_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog front end, digitised
    input wire logic [11:0] freq_control_voltage_input,
    // Nonvolatile storage image, loaded once after reset
    input wire logic signed [15:0] nv_magnetic_offset_cal,
    input wire logic nv_lock_enable_setting,
    // Reference and local timing
    input wire logic ref_pps,
    output logic local_pps,
    output logic sync_ind,
    // Magnetic field setting and interrupt
    output logic [15:0] mag_setting,
    output logic irq
);
    typedef struct packed {
        ppsd_pkg::ppsd_state_t st;
        logic loaded;
        logic serial_ovr;
        logic signed [11:0] freq_set_value;
        logic signed [15:0] magnetic_offset_cal;
        logic lock_enable_setting;
        logic [3:0] loop_time_constant_sel;
        logic [23:0] sec_cnt;
        logic [23:0] tag_first;
        logic [23:0] tag_last;
        logic [23:0] tag_now;
        logic [8:0] good_cnt;
        logic [8:0] bad_cnt;
        logic [27:0] miss_cnt;
        logic ref_d;
        logic pi_step;
        logic pps_out;
        logic sync;
        logic [ppsd_pkg::IRQ_W-1:0] irq_stat;
        logic [ppsd_pkg::IRQ_W-1:0] irq_mask;
        logic irq;
        logic aw_ok;
        logic [7:0] aw_addr;
        logic w_ok;
        logic [31:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ppsd_top_t;
    ppsd_top_t r, next_r;

    logic signed [11:0] pi_fsv;
    logic [15:0] mag_val;

    ppsd_pi_filter #(.W(32)) u_pi (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(r.st != ppsd_pkg::ST_LOCK),
        .step(r.pi_step),
        .phase_ns(phase_ns(r.tag_last)),
        .tc_sel(r.loop_time_constant_sel),
        .fsv_out(pi_fsv)
    );

    ppsd_mag_calc u_mag (
        .aclk(aclk),
        .aresetn(aresetn),
        .moff(r.magnetic_offset_cal),
        .fsv(r.freq_set_value),
        .mag(mag_val)
    );

    // Signed offset of a tag from the local second, in ns, saturated
    function automatic logic signed [15:0] phase_ns(input logic [23:0] t);
        logic signed [25:0] d;
        d = (t >= 24'(ppsd_pkg::SEC_CLKS / 2)) ? 26'(t) - 26'(ppsd_pkg::SEC_CLKS) : 26'(t);
        d = d * 26'(ppsd_pkg::NS_PER_CLK);
        if (d > 26'sd32767) return 16'sh7fff;
        if (d < -26'sd32767) return -16'sh7fff;
        return d[15:0];
    endfunction

    // Distance of two tags modulo one second, in ns
    function automatic logic [31:0] dist_ns(input logic [23:0] a, input logic [23:0] b);
        logic [23:0] d;
        d = (a >= b) ? a - b : b - a;
        if (d > 24'(ppsd_pkg::SEC_CLKS / 2)) d = 24'(ppsd_pkg::SEC_CLKS) - d;
        return 32'(d) * 32'(ppsd_pkg::NS_PER_CLK);
    endfunction

    // Potentiometer maps centre to zero, clamped into the legal range
    function automatic logic signed [11:0] pot_fsv(input logic [11:0] v);
        logic signed [12:0] c;
        c = 13'(v) - 13'(ppsd_pkg::POT_CENTER); // see R5
        if (c > 13'sd2000) return 12'sd2000;
        if (c < -13'sd2000) return -12'sd2000;
        return c[11:0];
    endfunction

    logic edge_seen;
    logic good;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [ppsd_pkg::IRQ_W-1:0] ev;
    always_comb begin
        next_r = r;
        next_r.pi_step = 1'b0;
        wa = r.aw_addr;
        wd = r.w_data;
        ev = '0;
        // Nonvolatile image taken once, after reset release (see R6)
        if (!r.loaded) begin
            next_r.loaded = 1'b1;
            next_r.magnetic_offset_cal = nv_magnetic_offset_cal;
            next_r.lock_enable_setting = nv_lock_enable_setting;
            next_r.st = nv_lock_enable_setting ? ppsd_pkg::ST_ACQ : ppsd_pkg::ST_IDLE; // see R7
        end
        // Local second counter; pulse is one cycle at the wrap
        next_r.pps_out = 1'b0;
        if (r.sec_cnt == 24'(ppsd_pkg::SEC_CLKS - 1)) begin
            next_r.sec_cnt = '0;
            next_r.pps_out = 1'b1;
        end else begin
            next_r.sec_cnt = r.sec_cnt + 24'h00_0001;
        end
        // Edge time-tag, resolution one clock period (see R15)
        next_r.ref_d = ref_pps;
        edge_seen = ref_pps && !r.ref_d;
        good = 1'b0;
        if (edge_seen) begin
            next_r.tag_now = r.sec_cnt;
            next_r.miss_cnt = '0;
        end else if (r.miss_cnt != 28'(ppsd_pkg::MISS_CLKS)) begin
            next_r.miss_cnt = r.miss_cnt + 28'h000_0001;
        end
        // A missing pulse drops sync (see R16)
        if (r.miss_cnt == 28'(ppsd_pkg::MISS_CLKS - 1)) begin
            next_r.sync = 1'b0;
            ev[ppsd_pkg::IRQ_MISS] = 1'b1;
        end
        if (edge_seen && r.loaded) begin
            unique case (r.st)
                ppsd_pkg::ST_IDLE: begin
                end
                ppsd_pkg::ST_ACQ: begin
                    if (r.good_cnt == '0) begin
                        next_r.tag_first = r.sec_cnt;
                        good = 1'b1;
                    end else begin
                        good = dist_ns(r.sec_cnt, r.tag_first) <= 32'(ppsd_pkg::GOOD_WIN_NS); // see R8
                    end
                    if (good) begin
                        next_r.tag_last = r.sec_cnt;
                        next_r.good_cnt = r.good_cnt + 9'h001;
                        if (r.good_cnt == 9'(ppsd_pkg::RUN_COUNT - 1)) begin
                            // Realign second to this tag, then sync (see R9)
                            next_r.sec_cnt = 24'h00_0001;
                            next_r.tag_last = '0;
                            next_r.st = ppsd_pkg::ST_LOCK;
                            next_r.sync = 1'b1;
                            next_r.good_cnt = '0;
                            ev[ppsd_pkg::IRQ_ACQ] = 1'b1;
                        end
                    end else begin
                        next_r.good_cnt = '0; // see R19
                    end
                end
                ppsd_pkg::ST_LOCK: begin
                    good = dist_ns(r.sec_cnt, r.tag_last) <= 32'(ppsd_pkg::LOCK_WIN_NS); // see R10
                    if (good) begin
                        next_r.tag_last = r.sec_cnt;
                        next_r.bad_cnt = '0; // see R19
                        next_r.pi_step = 1'b1; // see R11
                        next_r.sync = dist_ns(r.sec_cnt, 24'h00_0000)
                            <= 32'(ppsd_pkg::SYNC_WIN_NS); // see R16
                    end else begin
                        next_r.sync = 1'b0;
                        next_r.bad_cnt = r.bad_cnt + 9'h001;
                        if (r.bad_cnt == 9'(ppsd_pkg::RUN_COUNT - 1)) begin
                            next_r.st = ppsd_pkg::ST_ACQ; // see R12
                            next_r.bad_cnt = '0;
                            next_r.good_cnt = '0;
                            ev[ppsd_pkg::IRQ_ABORT] = 1'b1;
                        end
                    end
                end
            endcase
            if (r.st != ppsd_pkg::ST_IDLE) begin
                if (good) ev[ppsd_pkg::IRQ_GOOD] = 1'b1;
                else ev[ppsd_pkg::IRQ_BAD] = 1'b1;
            end
        end
        // Frequency-set source: loop first, then serial, then pot (see R17)
        if (r.st == ppsd_pkg::ST_LOCK) begin
            next_r.freq_set_value = pi_fsv;
        end else if (!r.serial_ovr) begin
            next_r.freq_set_value = pot_fsv(freq_control_voltage_input); // see R2
        end
        // AXI4-Lite write channel, address and data in either order
        if (s_axi_awvalid && !r.aw_ok) begin
            next_r.aw_ok = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
            wa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_ok) begin
            next_r.w_ok = 1'b1;
            next_r.w_data = s_axi_wdata;
            wd = s_axi_wdata;
        end
        if (next_r.aw_ok && next_r.w_ok && !r.bvalid) begin
            next_r.aw_ok = 1'b0;
            next_r.w_ok = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = ppsd_pkg::RESP_OKAY;
            unique case (wa)
                ppsd_pkg::REG_FSV: begin
                    if (r.st != ppsd_pkg::ST_LOCK) begin
                        next_r.serial_ovr = 1'b1;
                        next_r.freq_set_value = pot_fsv(12'(wd[11:0]) + ppsd_pkg::POT_CENTER);
                    end
                end
                ppsd_pkg::REG_MOFF: next_r.magnetic_offset_cal = wd[15:0]; // see R6
                ppsd_pkg::REG_CTRL: begin
                    next_r.lock_enable_setting = wd[ppsd_pkg::CTRL_LOCK_EN];
                    if (wd[ppsd_pkg::CTRL_TC_LSB +: 4] <= ppsd_pkg::TC_MAX) begin
                        next_r.loop_time_constant_sel = wd[ppsd_pkg::CTRL_TC_LSB +: 4]; // see R14
                    end
                end
                ppsd_pkg::REG_IRQ_STAT: next_r.irq_stat = r.irq_stat & ~wd[4:0];
                ppsd_pkg::REG_IRQ_MASK: next_r.irq_mask = wd[4:0];
                default: next_r.bresp = ppsd_pkg::RESP_SLVERR;
            endcase
        end
        if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;
        // AXI4-Lite read channel
        if (s_axi_arvalid && !r.rvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = ppsd_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                ppsd_pkg::REG_FSV: next_r.rdata = 32'(r.freq_set_value);
                ppsd_pkg::REG_MOFF: next_r.rdata = 32'(r.magnetic_offset_cal);
                ppsd_pkg::REG_CTRL: next_r.rdata = {24'h00_0000, r.loop_time_constant_sel,
                    3'h0, r.lock_enable_setting};
                ppsd_pkg::REG_STATUS: next_r.rdata = {11'h000, r.bad_cnt, r.good_cnt,
                    r.serial_ovr, r.sync, r.st == ppsd_pkg::ST_LOCK};
                ppsd_pkg::REG_IRQ_STAT: next_r.rdata = 32'(r.irq_stat);
                ppsd_pkg::REG_IRQ_MASK: next_r.rdata = 32'(r.irq_mask);
                ppsd_pkg::REG_TAG: next_r.rdata = 32'(r.tag_now);
                ppsd_pkg::REG_MAG: next_r.rdata = 32'(mag_val);
                default: begin
                    next_r.rdata = '0;
                    next_r.rresp = ppsd_pkg::RESP_SLVERR;
                end
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        // Events applied after the clear, so a set in the same cycle wins
        next_r.irq_stat = next_r.irq_stat | ev;
        next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
    end

    // Reset discards serial override and restores defaults (see R3, R13)
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= ppsd_pkg::ST_IDLE;
            r.lock_enable_setting <= ppsd_pkg::LOCK_EN_DEFAULT;
            r.loop_time_constant_sel <= ppsd_pkg::TC_DEFAULT;
        end else begin
            r <= next_r;
        end
    end

    assign s_axi_awready = !r.aw_ok;
    assign s_axi_wready = !r.w_ok;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign local_pps = r.pps_out;
    assign sync_ind = r.sync;
    assign mag_setting = mag_val;
    assign irq = r.irq;
endmodule

// ==== rtl/ppsd_pkg.sv ====
// Overview of operation
// R1 - Frequency-set value is signed, clamped to plus or minus 2000 counts
// R2 - Potentiometer drives the value until a serial write or loop lock
// R3 - Reset returns control to the potentiometer, dropping serial override
// R4 - Magnetic setting is root of sum of squares of offset and value
// R5 - Centered potentiometer gives a value of zero
// R6 - Magnetic offset is software writable and kept across resets; code reloads it from nv_magnetic_offset_cal at each reset
// R7 - Loop enabled at reset only when stored lock enable is one, default one
// R8 - Loop takes control after 256 consecutive pulses within 2048 ns of first
// R9 - On acquisition realign local 1 pps to last tag and assert sync
// R10 - While locked, pulses over 1024 ns from last good are bad
// R11 - PI filter on good tags updates the value once per second
// R12 - 256 consecutive bad pulses abort the loop and restart acquisition
// R13 - Time constant setting chooses the loop gains, default 8
// R14 - Settings 0 to 14 accepted, integral gain halves each step
// R15 - Reference edges are time-tagged against the local timebase
// R16 - Sync only while pulses present and within 1 us; one miss drops it
// R17 - A detected reference gives the loop priority over the potentiometer
// R18 - Serial settings are 9600 baud 8N1, no flow control, fixed; code has no serial port and only defines the unused SERIAL_BAUD
// R19 - A bad pulse clears the good count, a good pulse the bad count
package ppsd_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int NS_PER_CLK = 1_000_000_000 / CLK_HZ;
    localparam int SEC_CLKS = CLK_HZ;
    localparam int FSV_LIMIT = 2000;
    localparam int GOOD_WIN_NS = 2048;
    localparam int LOCK_WIN_NS = 1024;
    localparam int SYNC_WIN_NS = 1000;
    localparam int RUN_COUNT = 256;
    localparam int SERIAL_BAUD = 9600; // see R18
    localparam int MISS_NS = 1_100_000_000;
    localparam int MISS_CLKS = MISS_NS / NS_PER_CLK;
    localparam logic [3:0] TC_DEFAULT = 4'h8;
    localparam logic [3:0] TC_MAX = 4'he;
    localparam logic LOCK_EN_DEFAULT = 1'b1;
    localparam logic [11:0] POT_CENTER = 12'h0800;
    // AXI4-Lite byte offsets
    localparam logic [7:0] REG_FSV = 8'h00;
    localparam logic [7:0] REG_MOFF = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;
    localparam logic [7:0] REG_TAG = 8'h18;
    localparam logic [7:0] REG_MAG = 8'h1c;
    // Control fields
    localparam int CTRL_LOCK_EN = 0;
    localparam int CTRL_TC_LSB = 4;
    // Interrupt bits
    localparam int IRQ_GOOD = 0;
    localparam int IRQ_BAD = 1;
    localparam int IRQ_ACQ = 2;
    localparam int IRQ_ABORT = 3;
    localparam int IRQ_MISS = 4;
    localparam int IRQ_W = 5;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum {ST_IDLE, ST_ACQ, ST_LOCK} ppsd_state_t;
endpackage

// ==== rtl/ppsd_pi_filter.sv ====
`timescale 1ns/10ps
// Second order PI loop filter, one update per good tag.
module ppsd_pi_filter #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic clear,
    input wire logic step,
    input wire logic signed [15:0] phase_ns,
    input wire logic [3:0] tc_sel,
    // Result
    output logic signed [11:0] fsv_out
);
    typedef struct packed {
        logic signed [W-1:0] integ;
        logic signed [11:0] fsv;
    } ppsd_pif_t;
    ppsd_pif_t r, next_r;

    // Proportional gains in Q12 per ns; integral halves per step (see R14)
    function automatic logic signed [W-1:0] prop_gain(input logic [3:0] t);
        logic [15:0] g;
        g = 16'h0000;
        unique case (t)
            4'h0: g = 16'h3f33; 4'h1: g = 16'h2ccd; 4'h2: g = 16'h1fae;
            4'h3: g = 16'h1666; 4'h4: g = 16'h0fd7; 4'h5: g = 16'h0b33;
            4'h6: g = 16'h07d7; 4'h7: g = 16'h0599; 4'h8: g = 16'h0400;
            4'h9: g = 16'h02b8; 4'ha: g = 16'h01eb; 4'hb: g = 16'h0170;
            4'hc: g = 16'h00f5; 4'hd: g = 16'h00a3; default: g = 16'h007a;
        endcase
        return W'(g);
    endfunction

    logic signed [W-1:0] err;
    logic signed [W-1:0] sum;
    always_comb begin
        next_r = r;
        err = W'(phase_ns);
        // Integral held in Q16: err << (8 - tc) per second, 0.055 per hour at 8
        sum = r.integ + ((err <<< 10) >>> (5'(tc_sel) + 5'd2));
        if (clear) begin
            next_r.integ = '0;
        end else if (step) begin // see R11
            next_r.integ = sum;
            next_r.fsv = sat(-((sum >>> 16) + ((err * prop_gain(tc_sel)) >>> 12))); // see R13
        end
    end

    // Clamp to the documented range (see R1)
    function automatic logic signed [11:0] sat(input logic signed [W-1:0] v);
        if (v > W'(2000)) return 12'sd2000;
        if (v < -W'(2000)) return -12'sd2000;
        return v[11:0];
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign fsv_out = r.fsv;
endmodule

// ==== rtl/ppsd_mag_calc.sv ====
`timescale 1ns/10ps
// Quadrature sum, sequential integer square root; latency 17 cycles.
module ppsd_mag_calc (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Operands
    input wire logic signed [15:0] moff,
    input wire logic signed [11:0] fsv,
    // Result
    output logic [15:0] mag
);
    typedef struct packed {
        logic [31:0] rem;
        logic [15:0] root;
        logic [4:0] bitn;
        logic [15:0] mag;
    } ppsd_mag_t;
    ppsd_mag_t r, next_r;
    logic [31:0] sq;
    logic [15:0] trial;
    logic [31:0] tsq;
    logic [15:0] am;
    logic [15:0] af;
    always_comb begin
        next_r = r;
        am = moff[15] ? 16'(-moff) : 16'(moff);
        af = fsv[11] ? 16'(-16'(fsv)) : 16'(16'(fsv));
        sq = 32'(am) * 32'(am) + 32'(af) * 32'(af); // see R4
        trial = r.root | (16'h0001 << r.bitn[3:0]);
        tsq = 32'(trial) * 32'(trial);
        if (r.bitn == 5'h10) begin
            next_r.mag = r.root;
            next_r.rem = sq;
            next_r.root = '0;
            next_r.bitn = 5'h0f;
        end else begin
            if (tsq <= r.rem) begin
                next_r.root = trial;
            end
            next_r.bitn = (r.bitn == 5'h00) ? 5'h10 : r.bitn - 5'h01;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '{rem: '0, root: '0, bitn: 5'h10, mag: '0};
        end else begin
            r <= next_r;
        end
    end
    assign mag = r.mag;
endmodule

// ==== tb/ppsd_top_sva.sv ====
`timescale 1ns/10ps
module ppsd_top_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    input wire logic irq
);
    // Address of the read under way, so read data can be judged per register
    logic [7:0] rd_addr;
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("outputs active after reset");
    chk_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid)
        else $error("no write response");
    chk_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("no read data");
    chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    chk_wr_unmapped: assert property (s_wr_taken ##0 (s_axi_awaddr > ppsd_pkg::REG_MAG)
        |=> s_axi_bresp == ppsd_pkg::RESP_SLVERR) else $error("unmapped write accepted");
    chk_fsv_range: assert property (s_axi_rvalid && rd_addr == ppsd_pkg::REG_FSV |->
        $signed(s_axi_rdata[11:0]) >= -ppsd_pkg::FSV_LIMIT
        && $signed(s_axi_rdata[11:0]) <= ppsd_pkg::FSV_LIMIT) else $error("value out of range");
    chk_tc_range: assert property (s_axi_rvalid && rd_addr == ppsd_pkg::REG_CTRL |->
        s_axi_rdata[7:4] <= ppsd_pkg::TC_MAX) else $error("time constant out of range");
endmodule
bind ppsd_top ppsd_top_sva u_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
);

// ==== tb/ppsd_ref_src.sv ====
`timescale 1ns/10ps
module ppsd_ref_src #(
    parameter int HIGH_CLKS = 4
) (
    // Clock and command
    input wire logic aclk,
    input wire logic fire,
    // Reference pulse, idle low
    output logic ref_pps
);
    int left = 0;
    // Width is arbitrary: only the rising edge carries timing
    always @(posedge aclk) begin
        if (fire) left <= HIGH_CLKS;
        else if (left > 0) left <= left - 1;
    end
    assign ref_pps = (left > 0);
endmodule

// ==== tb/pps_discipline_freq_control_bench.sv ====
`timescale 1ns/10ps
module pps_discipline_freq_control_bench;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [11:0] pot = ppsd_pkg::POT_CENTER;
    logic signed [15:0] nv_moff = 16'h0064;
    logic nv_lock = 1'h1;
    logic fire = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, ref_pps, irq;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    logic [15:0] mag_setting;
    logic [3:0] tc_in [3] = '{4'he, 4'h0, 4'hf};
    logic [3:0] tc_exp [3] = '{4'he, 4'h0, 4'h0};
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    always #50 aclk = ~aclk;
    ppsd_top u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .freq_control_voltage_input(pot), .nv_magnetic_offset_cal(nv_moff),
        .nv_lock_enable_setting(nv_lock), .ref_pps(ref_pps), .local_pps(), .sync_ind(),
        .mag_setting(mag_setting), .irq(irq)
    );
    ppsd_ref_src u_ref (.aclk(aclk), .fire(fire), .ref_pps(ref_pps));
    task automatic wrap_up();
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!(bvalid && bready));
        rsp = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!(rvalid && rready));
        rd = rdata;
        rsp = rresp;
        rready <= 1'h0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd_reg(a);
        check(rd & m, e);
    endtask
    task automatic pulse();
        @(posedge aclk);
        fire <= 1'h1;
        @(posedge aclk);
        fire <= 1'h0;
    endtask
    task automatic do_reset();
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
    endtask
    task automatic t_defaults();
        rchk(ppsd_pkg::REG_CTRL, 32'h0000_00f1, 32'h0000_0081);
        rchk(ppsd_pkg::REG_FSV, 32'h0000_0fff, 32'h0000_0000);
        rchk(ppsd_pkg::REG_MOFF, 32'h0000_ffff, 32'h0000_0064);
        check(32'(irq), 32'h0000_0000);
    endtask
    task automatic t_override();
        wr(ppsd_pkg::REG_FSV, 32'h0000_07ff);
        check(32'(rsp), 32'(ppsd_pkg::RESP_OKAY));
        rchk(ppsd_pkg::REG_FSV, 32'h0000_0fff, 32'h0000_07d0);
        wr(ppsd_pkg::REG_FSV, 32'h0000_0800);
        rchk(ppsd_pkg::REG_FSV, 32'h0000_0fff, 32'h0000_0830);
        pot <= 12'hc00;
        repeat (4) @(posedge aclk);
        rchk(ppsd_pkg::REG_FSV, 32'h0000_0fff, 32'h0000_0830);
    endtask
    task automatic t_mag();
        wr(ppsd_pkg::REG_MOFF, 32'h0000_012c);
        wr(ppsd_pkg::REG_FSV, 32'h0000_0190);
        // Root takes 17 cycles and restarts every 17, so two rounds suffice
        repeat (40) @(posedge aclk);
        check({16'h0000, mag_setting}, 32'h0000_01f4);
        rchk(ppsd_pkg::REG_MAG, 32'h0000_ffff, 32'h0000_01f4);
    endtask
    task automatic t_tc();
        for (int i = 0; i < 3; i++) begin
            wr(ppsd_pkg::REG_CTRL, {24'h00_0000, tc_in[i], 4'h1});
            rchk(ppsd_pkg::REG_CTRL, 32'h0000_00f0, {24'h00_0000, tc_exp[i], 4'h0});
        end
    endtask
    task automatic t_unmapped();
        wr(8'h40, 32'h0000_0000);
        check(32'(rsp), 32'(ppsd_pkg::RESP_SLVERR));
        rd_reg(8'h40);
        check(32'(rsp), 32'(ppsd_pkg::RESP_SLVERR));
    endtask
    task automatic t_events();
        wr(ppsd_pkg::REG_IRQ_MASK, 32'h0000_001f);
        rchk(ppsd_pkg::REG_IRQ_MASK, 32'h0000_001f, 32'h0000_001f);
        pulse();
        repeat (10) @(posedge aclk);
        rd_reg(ppsd_pkg::REG_IRQ_STAT);
        check(32'(rd[ppsd_pkg::IRQ_GOOD]), 32'h0000_0001);
        check(32'(irq), 32'h0000_0001);
        // Second edge some microseconds later lies far outside the window
        repeat (40) @(posedge aclk);
        pulse();
        repeat (10) @(posedge aclk);
        rd_reg(ppsd_pkg::REG_IRQ_STAT);
        check(32'(rd[ppsd_pkg::IRQ_BAD]), 32'h0000_0001);
        rchk(ppsd_pkg::REG_STATUS, 32'h0000_0003, 32'h0000_0000);
        wr(ppsd_pkg::REG_IRQ_MASK, 32'h0000_0000);
        repeat (3) @(posedge aclk);
        check(32'(irq), 32'h0000_0000);
        wr(ppsd_pkg::REG_IRQ_MASK, 32'h0000_001f);
        wr(ppsd_pkg::REG_IRQ_STAT, 32'h0000_001f);
        rchk(ppsd_pkg::REG_IRQ_STAT, 32'h0000_001f, 32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
    endtask
    task automatic t_restart();
        pot <= ppsd_pkg::POT_CENTER;
        nv_lock <= 1'h0;
        nv_moff <= 16'hff38;
        do_reset();
        rchk(ppsd_pkg::REG_FSV, 32'h0000_0fff, 32'h0000_0000);
        rchk(ppsd_pkg::REG_MOFF, 32'h0000_ffff, 32'h0000_ff38);
        rchk(ppsd_pkg::REG_CTRL, 32'h0000_00f1, 32'h0000_0080);
    endtask
    initial begin
        do_reset();
        t_defaults();
        t_override();
        t_mag();
        t_tc();
        t_unmapped();
        t_events();
        t_restart();
        wrap_up();
    end
endmodule
